//--- ocpa_pkg.sv
// Constants, register map and types shared by the output stage files.
// Assumes one clock domain: the divider clock drives every flop.
package ocpa_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LEN_W = 34;
  localparam int unsigned SUM_W = 36;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_DIV = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_HIGH = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_SHIFT = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 12'h014;

  // Control field positions
  localparam int unsigned CTRL_W = 7;
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_DUAL = 1;
  localparam int unsigned CTRL_DUTY = 2;
  localparam int unsigned CTRL_SE0 = 3;
  localparam int unsigned CTRL_INV0 = 4;
  localparam int unsigned CTRL_SE1 = 5;
  localparam int unsigned CTRL_INV1 = 6;

  // Status field positions
  localparam int unsigned STAT_PEND = 0;
  localparam int unsigned STAT_LEVEL = 1;
  localparam int unsigned STAT_REJ = 2;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [DATA_W-1:0] DIV_RST = 32'h0000_0008;
  localparam logic [DATA_W-1:0] HIGH_RST = 32'h0000_0000;

  // Divider and phase limits in divider clock periods
  localparam logic [DATA_W-1:0] MIN_DIV = 32'h0000_0002;
  localparam logic [DATA_W-1:0] MIN_SHIFT_DIV = 32'h0000_0005;
  localparam logic [LEN_W-1:0] MIN_PHASE = 34'h0_0000_0002;
  localparam logic [LEN_W-1:0] CNT_LAST = 34'h0_0000_0001;

  typedef enum logic {PH_HIGH, PH_LOW} phase_t;

endpackage

//--- apb_port.sv
// APB slave front end: decode, handshake and error answer.
// Assumes an APB master on clk; no wait states are ever inserted.
`timescale 1ns/10ps
`default_nettype none
module apb_port
  import ocpa_pkg::*;
(
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  // Answer
  output logic pready,
  output logic pslverr,
  // Strobes toward the register file
  output logic wr_stb,
  output logic rd_setup
);
  logic mapped;

  always_comb begin
    unique case (paddr)
      OFS_CTRL, OFS_DIV, OFS_HIGH, OFS_SHIFT, OFS_STATUS, OFS_COUNT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Zero wait states keep the shift latency fixed for software
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wr_stb = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
endmodule
`default_nettype wire

//--- pad_drive.sv
// One output buffer path: differential or paired single-ended drive.
// Assumes the clock level arrives from logic on the same clk.
`timescale 1ns/10ps
`default_nettype none
module pad_drive (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Level and settings
  input wire logic level,
  input wire logic enable,
  input wire logic single_ended,
  input wire logic invert,
  // Buffer drive
  output logic true_pad,
  output logic complement_pad,
  output logic diff_mode
);
  typedef struct packed {
    logic tp;
    logic cp;
    logic dm;
  } pad_state_t;

  pad_state_t st_r;
  pad_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.dm = ~single_ended;
    st_nxt.tp = enable & level;
    // Duty logic only makes high pulses; a low pulse needs the inverter
    if (!single_ended) begin
      // A parked pair still drives complementary legs
      st_nxt.cp = ~st_nxt.tp;
    end else if (!enable) begin
      st_nxt.cp = 1'b0;
    end else begin
      st_nxt.cp = invert ? ~level : level;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign true_pad = st_r.tp;
  assign complement_pad = st_r.cp;
  assign diff_mode = st_r.dm;
endmodule
`default_nettype wire

//--- output_coarse_phase_adjust.sv
// Output stage of a clock generator: integer divider, high width,
// coarse phase shift and two buffer paths behind an APB register file.
// Assumes clk is the divider clock and the APB master shares it.
`timescale 1ns/10ps
`default_nettype none
module output_coarse_phase_adjust
  import ocpa_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Divided clock level before the buffers
  output logic out_clk,
  // Buffer path 0
  output logic true_pad0,
  output logic complement_pad0,
  output logic diff_mode0,
  // Buffer path 1, used by a dual stage
  output logic true_pad1,
  output logic complement_pad1,
  output logic diff_mode1
);

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [DATA_W-1:0] div;
    logic [DATA_W-1:0] high;
    logic [DATA_W-1:0] shift;
    logic pend;
    logic rej;
    logic [DATA_W-1:0] applied;
    phase_t ph;
    logic [LEN_W-1:0] cnt;
    logic [LEN_W-1:0] lo_len;
    logic out;
    logic [DATA_W-1:0] rdata;
  } stage_state_t;

  stage_state_t st_r;
  stage_state_t st_nxt;

  logic wr_stb;
  logic rd_setup;

  // Values evaluated for the next output period
  logic [DATA_W-1:0] div_eff;
  logic duty_on;
  logic [LEN_W-1:0] base_hi;
  logic [LEN_W-1:0] base_lo;
  logic shift_ok;
  logic signed [SUM_W-1:0] shift_ext;
  logic signed [SUM_W-1:0] hi_adj;
  logic signed [SUM_W-1:0] lo_adj;
  logic [LEN_W-1:0] hi_len;
  logic [LEN_W-1:0] lo_len;
  logic boundary;

  apb_port u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pready(pready),
    .pslverr(pslverr),
    .wr_stb(wr_stb),
    .rd_setup(rd_setup)
  );

  // Adds a signed offset to a length, never going below the least phase
  function automatic logic [LEN_W-1:0] adjust_len(
    input logic [LEN_W-1:0] base,
    input logic signed [SUM_W-1:0] adj
  );
    logic signed [SUM_W-1:0] sum;
    sum = $signed({2'b00, base}) + adj;
    if (sum < $signed({2'b00, MIN_PHASE})) begin
      adjust_len = MIN_PHASE;
    end else begin
      adjust_len = sum[LEN_W-1:0];
    end
  endfunction

  // Period plan, sampled only at the start of each output period
  always_comb begin
    // Ratios below two cannot come from a flop and run as two
    div_eff = (st_r.div < MIN_DIV) ? MIN_DIV : st_r.div;
    // A width at or above the ratio falls back to half duty
    duty_on = st_r.ctrl[CTRL_DUTY] && (st_r.high != '0)
      && (st_r.high < div_eff);
    if (duty_on) begin
      base_hi = {2'b00, st_r.high};
    end else begin
      base_hi = {3'b000, div_eff[DATA_W-1:1]};
    end
    base_lo = {2'b00, div_eff} - base_hi;

    // Ratios of four or less have no room for two plus two
    shift_ok = st_r.pend && (div_eff >= MIN_SHIFT_DIV);
    shift_ext = $signed({{(SUM_W-DATA_W){st_r.shift[DATA_W-1]}}, st_r.shift});
    if (duty_on) begin
      hi_adj = '0;
    end else begin
      hi_adj = shift_ext >>> 1;
    end
    lo_adj = shift_ext - hi_adj;

    if (shift_ok) begin
      hi_len = adjust_len(base_hi, hi_adj);
      lo_len = adjust_len(base_lo, lo_adj);
    end else begin
      hi_len = base_hi;
      lo_len = base_lo;
    end
  end

  assign boundary = st_r.ctrl[CTRL_RUN] && (st_r.ph == PH_LOW) && (st_r.cnt == CNT_LAST);

  always_comb begin
    st_nxt = st_r;

    // Output period generator, counted in divider clock periods
    if (!st_r.ctrl[CTRL_RUN]) begin
      // Parked so the first enabled cycle starts a fresh period
      st_nxt.ph = PH_LOW;
      st_nxt.cnt = CNT_LAST;
      st_nxt.out = 1'b0;
    end else begin
      unique case (st_r.ph)
        PH_HIGH: begin
          if (st_r.cnt == CNT_LAST) begin
            st_nxt.ph = PH_LOW;
            st_nxt.cnt = st_r.lo_len;
            st_nxt.out = 1'b0;
          end else begin
            st_nxt.cnt = st_r.cnt - CNT_LAST;
          end
        end
        PH_LOW: begin
          if (st_r.cnt == CNT_LAST) begin
            // Whole shift lands in the period that starts here
            st_nxt.ph = PH_HIGH;
            st_nxt.cnt = hi_len;
            st_nxt.lo_len = lo_len;
            st_nxt.out = 1'b1;
          end else begin
            st_nxt.cnt = st_r.cnt - CNT_LAST;
          end
        end
      endcase
    end

    // Shift consumption at the boundary
    if (boundary && st_r.pend) begin
      st_nxt.pend = 1'b0;
      if (shift_ok) begin
        st_nxt.applied = st_r.applied + 32'h0000_0001;
      end else begin
        st_nxt.rej = 1'b1;
      end
    end

    // Register writes; a new shift wins over its own consumption
    if (wr_stb) begin
      unique case (paddr)
        OFS_CTRL: st_nxt.ctrl = pwdata[CTRL_W-1:0];
        OFS_DIV: st_nxt.div = pwdata;
        OFS_HIGH: st_nxt.high = pwdata;
        OFS_SHIFT: begin
          st_nxt.shift = pwdata;
          st_nxt.pend = 1'b1;
        end
        OFS_STATUS: begin
          // Write one clears, but a rejection in this cycle stays
          if (pwdata[STAT_REJ] && !(boundary && st_r.pend && !shift_ok)) begin
            st_nxt.rej = 1'b0;
          end
        end
        OFS_COUNT: st_nxt.applied = pwdata;
        default: st_nxt.applied = st_nxt.applied;
      endcase
    end

    // Read data is captured in the setup cycle and held for the access
    if (rd_setup) begin
      unique case (paddr)
        OFS_CTRL: st_nxt.rdata = {{(DATA_W-CTRL_W){1'b0}}, st_r.ctrl};
        OFS_DIV: st_nxt.rdata = st_r.div;
        OFS_HIGH: st_nxt.rdata = st_r.high;
        OFS_SHIFT: st_nxt.rdata = st_r.shift;
        OFS_STATUS: begin
          st_nxt.rdata = '0;
          st_nxt.rdata[STAT_PEND] = st_r.pend;
          st_nxt.rdata[STAT_LEVEL] = st_r.out;
          st_nxt.rdata[STAT_REJ] = st_r.rej;
        end
        OFS_COUNT: st_nxt.rdata = st_r.applied;
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r.ctrl <= CTRL_RST;
      st_r.div <= DIV_RST;
      st_r.high <= HIGH_RST;
      st_r.shift <= '0;
      st_r.pend <= 1'b0;
      st_r.rej <= 1'b0;
      st_r.applied <= '0;
      st_r.ph <= PH_LOW;
      st_r.cnt <= CNT_LAST;
      st_r.lo_len <= CNT_LAST;
      st_r.out <= 1'b0;
      st_r.rdata <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rdata;
  assign out_clk = st_r.out;

  // Both paths share one divided level, so they stay in phase
  pad_drive u_path0 (
    .clk(clk),
    .sys_rst(sys_rst),
    .level(st_r.out),
    .enable(st_r.ctrl[CTRL_RUN]),
    .single_ended(st_r.ctrl[CTRL_SE0]),
    .invert(st_r.ctrl[CTRL_INV0]),
    .true_pad(true_pad0),
    .complement_pad(complement_pad0),
    .diff_mode(diff_mode0)
  );

  pad_drive u_path1 (
    .clk(clk),
    .sys_rst(sys_rst),
    .level(st_r.out),
    .enable(st_r.ctrl[CTRL_RUN] & st_r.ctrl[CTRL_DUAL]),
    .single_ended(st_r.ctrl[CTRL_SE1]),
    .invert(st_r.ctrl[CTRL_INV1]),
    .true_pad(true_pad1),
    .complement_pad(complement_pad1),
    .diff_mode(diff_mode1)
  );

endmodule
`default_nettype wire

//--- clock_receiver.sv
// Downstream receiver model: measures high and low run lengths of a pad.
// Assumes the pad is sampled on the divider clock of the output stage.
`timescale 1ns/10ps
`default_nettype none
module clock_receiver (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Observed pad
  input wire logic pad,
  // Last completed period
  output logic per_done,
  output logic [31:0] hi_len,
  output logic [31:0] lo_len
);
  logic prev;
  logic [31:0] hi_cnt;
  logic [31:0] lo_cnt;
  // A receiver only listens; it drives nothing back into the stage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev <= 1'b0;
      per_done <= 1'b0;
      hi_cnt <= 32'h0000_0000;
      lo_cnt <= 32'h0000_0000;
      hi_len <= 32'h0000_0000;
      lo_len <= 32'h0000_0000;
    end else begin
      prev <= pad;
      per_done <= pad && !prev;
      if (pad) begin
        hi_cnt <= (prev ? hi_cnt : 32'h0000_0000) + 32'h0000_0001;
      end else begin
        lo_cnt <= (prev ? 32'h0000_0000 : lo_cnt) + 32'h0000_0001;
      end
      // First period after start carries an idle low count
      if (pad && !prev) begin
        hi_len <= hi_cnt;
        lo_len <= lo_cnt;
      end
    end
  end
endmodule
`default_nettype wire

//--- output_coarse_phase_adjust_assertions.sv
// Checker for the output stage, bound to the top module's ports.
// Assumes one clock domain and a bench that keeps every portion at two or more.
`timescale 1ns/10ps
`default_nettype none
module ocpa_assertions
  import ocpa_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Outputs
  input wire logic out_clk,
  input wire logic true_pad0,
  input wire logic complement_pad0,
  input wire logic diff_mode0,
  input wire logic true_pad1,
  input wire logic complement_pad1,
  input wire logic diff_mode1
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_hold_hi;
    out_clk ##1 out_clk;
  endsequence
  sequence s_hold_lo;
    !out_clk ##1 !out_clk;
  endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (psel && penable && !pwrite && paddr == 12'h020 |->
    pslverr && prdata == 32'h0000_0000) else $error("unmapped read not refused");
  a_mapped_ok: assert property (psel && penable && paddr <= OFS_COUNT && paddr[1:0] == 2'b00
    |-> !pslverr) else $error("mapped access refused");
  a_setup_quiet: assert property (psel && !penable |-> !pslverr) else $error("error in setup");
  a_high_min: assert property ($rose(out_clk) |-> s_hold_hi) else $error("short high");
  a_low_min: assert property ($fell(out_clk) |-> s_hold_lo) else $error("short low");
  a_pad_follow: assert property (1'b1 |-> true_pad0 == $past(out_clk))
    else $error("true pad not following");
  a_diff_comp: assert property (diff_mode0 && $past(diff_mode0) |->
    complement_pad0 != true_pad0) else $error("differential pair equal");
  a_path1_src: assert property (true_pad1 |-> $past(out_clk))
    else $error("second path from other source");
endmodule
bind output_coarse_phase_adjust ocpa_assertions chk (.clk(clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .out_clk(out_clk),
  .true_pad0(true_pad0), .complement_pad0(complement_pad0), .diff_mode0(diff_mode0),
  .true_pad1(true_pad1), .complement_pad1(complement_pad1), .diff_mode1(diff_mode1));
`default_nettype wire

//--- output_coarse_phase_adjust_tb_top.sv
// Self-checking bench: APB register tests, period lengths and pad modes.
// Assumes a receiver model on path 0 and a 100 MHz divider clock.
`timescale 1ns/10ps
`default_nettype none
module output_coarse_phase_adjust_tb_top
  import ocpa_pkg::*;
;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, err, per_done;
  logic out_clk, t0, c0, d0, t1, c1, d1;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, q, hi_len, lo_len;
  int n_errors, n_compared, cycles;
  logic [ADDR_W-1:0] ofs [6] = '{OFS_CTRL, OFS_DIV, OFS_HIGH, OFS_SHIFT, OFS_STATUS, OFS_COUNT};
  logic [DATA_W-1:0] rst_v [6] = '{{25'h000_0000, CTRL_RST}, DIV_RST, HIGH_RST,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  output_coarse_phase_adjust dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .out_clk(out_clk), .true_pad0(t0),
    .complement_pad0(c0), .diff_mode0(d0), .true_pad1(t1), .complement_pad1(c1),
    .diff_mode1(d1));
  clock_receiver rx (.clk(clk), .sys_rst(sys_rst), .pad(t0), .per_done(per_done),
    .hi_len(hi_len), .lo_len(lo_len));
  task stop_test;
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task check(input logic [DATA_W-1:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task per;
    do @(posedge clk); while (per_done !== 1'b1);
  endtask
  task period(input logic [DATA_W-1:0] eh, el);
    per;
    check(hi_len, eh);
    check(lo_len, el);
  endtask
  task settle(input logic [DATA_W-1:0] eh, el);
    per;
    per;
    period(eh, el);
  endtask
  // Write lands mid-period so the shifted period is the next one after
  task shift(input logic [DATA_W-1:0] d, eh, el);
    per;
    xfer(1'b1, OFS_SHIFT, d);
    per;
    period(eh, el);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      n_errors++;
      stop_test;
    end
  end
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, ofs[i], 32'h0000_0000);
      check(q, rst_v[i]);
    end
    xfer(1'b0, 12'h020, 32'h0000_0000);
    check(q, 32'h0000_0000);
    check({31'h0000_0000, err}, 32'h0000_0001);
    xfer(1'b1, OFS_CTRL, 32'h0000_0001);
    settle(32'h0000_0004, 32'h0000_0004);
    shift(32'h0000_0003, 32'h0000_0005, 32'h0000_0006);
    period(32'h0000_0004, 32'h0000_0004);
    shift(32'hFFFF_FFFE, 32'h0000_0003, 32'h0000_0003);
    xfer(1'b0, OFS_COUNT, 32'h0000_0000);
    check(q, 32'h0000_0002);
    xfer(1'b1, OFS_HIGH, 32'h0000_0003);
    xfer(1'b1, OFS_DIV, 32'h0000_000A);
    xfer(1'b1, OFS_CTRL, 32'h0000_0005);
    settle(32'h0000_0003, 32'h0000_0007);
    shift(32'h0000_0004, 32'h0000_0003, 32'h0000_000B);
    shift(32'hFFFF_FFFA, 32'h0000_0003, 32'h0000_0002);
    xfer(1'b0, OFS_COUNT, 32'h0000_0000);
    check(q, 32'h0000_0004);
    xfer(1'b0, OFS_DIV, 32'h0000_0000);
    check(q, 32'h0000_000A);
    xfer(1'b0, OFS_SHIFT, 32'h0000_0000);
    check(q, 32'hFFFF_FFFA);
    xfer(1'b1, OFS_COUNT, 32'h0000_0010);
    xfer(1'b0, OFS_COUNT, 32'h0000_0000);
    check(q, 32'h0000_0010);
    // Both paths get the same mode so path 1 must mirror path 0
    for (int m = 0; m < 4; m++) begin
      xfer(1'b1, OFS_CTRL, 32'h0000_0003 + 32'h0000_0028 * m);
      repeat (3) @(posedge clk);
      for (int k = 0; k < 12; k++) begin
        @(posedge clk);
        check({31'h0000_0000, c0}, {31'h0000_0000, m[0] ? t0 ^ m[1] : ~t0});
        check({31'h0000_0000, d0}, {31'h0000_0000, ~m[0]});
        check({29'h0000_0000, t1, c1, d1}, {29'h0000_0000, t0, c0, d0});
      end
    end
    stop_test;
  end
endmodule
`default_nettype wire
